// ---- hw/ssip_params.svh ----
/*
  constants of the serial position transmitter: widths, reset values, times and cycle counts.
  assumes a 100 MHz ref_clk; the serial clock comes from the master.
*/
// Behaviour
// - position rises clockwise when direction input is low, counterclockwise when high.
// - first falling serial clock edge of a transfer captures the position.
// - each following rising edge drives one bit, most significant first.
// - clocks beyond the word length shift out low bits after the word.
// - after the last clock wait about 12 us, then data high, ready.
// - word length is a build parameter of 16, 17 or 19 bits.
// - word is plain binary or gray, fixed at build time.
// - zero input high at least 100 us then released clears position.
`ifndef SSIP_PARAMS_SVH
`define SSIP_PARAMS_SVH

// ==========================================================
// clock and word
`define SSIP_CLK_NS 10
`define SSIP_POS_BITS 16
`define SSIP_POS_RST 0
`define SSIP_GRAY 0

// ==========================================================
// times and derived cycle counts (least times round up)
`define SSIP_REC_NS 12000
`define SSIP_REC_CYC ((`SSIP_REC_NS + `SSIP_CLK_NS - 1) / `SSIP_CLK_NS)
`define SSIP_ZERO_NS 100000
`define SSIP_ZERO_CYC ((`SSIP_ZERO_NS + `SSIP_CLK_NS - 1) / `SSIP_CLK_NS)

`endif

// ---- hw/ssip_pkg.sv ----
/*
  types of the serial position transmitter.
  assumes nothing of its surroundings.
*/
// ==========================================================
// link states seen from the ref_clk side
package ssip_pkg;
  typedef enum logic [0:0] {
    SSIP_READY,
    SSIP_BUSY
  } ssip_state_t;
endpackage : ssip_pkg

// ---- hw/ssip_transmitter.sv ----
/*
  serial position transmitter: position counter, zero input, frame capture,
  recovery timing on ref_clk, and the bit shifter on the master's serial clock.
  assumes rotation pulses come from logic on ref_clk; ssi_clk, dir_ccw and zero_in
  are pins; the master keeps clock rates and pauses within their limits.
*/
`timescale 1ns/1ps
`include "ssip_params.svh"

module ssip_transmitter
  import ssip_pkg::*;
#(
  parameter int unsigned POS_BITS = `SSIP_POS_BITS,
  parameter bit          GRAY     = `SSIP_GRAY,
  parameter int unsigned ZERO_CYC = `SSIP_ZERO_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                ssi_clk,
  input  wire logic                rot_cw,
  input  wire logic                rot_ccw,
  input  wire logic                dir_ccw,
  input  wire logic                zero_in,
  output logic                     sdo,
  output logic                     link_ready,
  output logic [POS_BITS-1:0]      position
);

  // ==========================================================
  // local sizes
  localparam int unsigned REC_W  = $clog2(`SSIP_REC_CYC + 1);
  localparam int unsigned ZW     = $clog2(ZERO_CYC + 1);
  localparam logic [REC_W-1:0] REC_LAST = REC_W'(`SSIP_REC_CYC - 1);
  localparam logic [ZW-1:0]    ZERO_MAX = ZW'(ZERO_CYC);

  // ==========================================================
  // pin synchronisers
  logic clk_s1;
  logic clk_s2;
  logic clk_s3;
  logic dir_s1;
  logic dir_s2;
  logic zero_s1;
  logic zero_s2;
  logic zero_s3;

  // two flops per pin, plus edge history
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_s1  <= 1'b1;
      clk_s2  <= 1'b1;
      clk_s3  <= 1'b1;
      dir_s1  <= 1'b0;
      dir_s2  <= 1'b0;
      zero_s1 <= 1'b0;
      zero_s2 <= 1'b0;
      zero_s3 <= 1'b0;
    end else begin
      clk_s1  <= ssi_clk;
      clk_s2  <= clk_s1;
      clk_s3  <= clk_s2;
      dir_s1  <= dir_ccw;
      dir_s2  <= dir_s1;
      zero_s1 <= zero_in;
      zero_s2 <= zero_s1;
      zero_s3 <= zero_s2;
    end
  end

  logic clk_fall;
  logic clk_edge;
  logic zero_rel;
  assign clk_fall = clk_s3 & ~clk_s2;
  assign clk_edge = clk_s3 ^ clk_s2;
  assign zero_rel = zero_s3 & ~zero_s2;

  // ==========================================================
  // position counter and zero input
  logic [POS_BITS-1:0] next_position;
  logic [ZW-1:0]       zero_cnt;
  logic [ZW-1:0]       next_zero_cnt;
  logic                zero_hit;

  // zero wins; otherwise one step when exactly one of the two rotation pulses is high
  always_comb begin
    next_position = position;
    next_zero_cnt = zero_cnt;
    zero_hit      = zero_rel && (zero_cnt >= ZERO_MAX);
    if (zero_s2) begin
      if (zero_cnt != ZERO_MAX) begin
        next_zero_cnt = zero_cnt + 1'b1;
      end
    end else begin
      next_zero_cnt = '0;
    end
    if (zero_hit) begin
      next_position = '0;
    end else if (rot_cw ^ rot_ccw) begin
      if (rot_cw ^ dir_s2) begin
        next_position = position + 1'b1;
      end else begin
        next_position = position - 1'b1;
      end
    end
  end

  // position registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      position <= POS_BITS'(`SSIP_POS_RST);
      zero_cnt <= '0;
    end else begin
      position <= next_position;
      zero_cnt <= next_zero_cnt;
    end
  end

  // ==========================================================
  // output code and frame control on ref_clk
  logic [POS_BITS-1:0] code;
  logic [POS_BITS-1:0] snap;
  logic [POS_BITS-1:0] next_snap;
  ssip_state_t         state;
  ssip_state_t         next_state;
  logic [REC_W-1:0]    rec_cnt;
  logic [REC_W-1:0]    next_rec_cnt;
  logic                next_link_ready;

  // build-time coding choice
  assign code = GRAY ? (position ^ (position >> 1)) : position;

  // snapshot follows the code while ready, freezes on the first fall
  always_comb begin
    next_state   = state;
    next_snap    = snap;
    next_rec_cnt = rec_cnt;
    case (state)
      SSIP_READY: begin
        next_snap    = code;
        next_rec_cnt = '0;
        if (clk_fall) begin
          next_state = SSIP_BUSY;
        end
      end
      SSIP_BUSY: begin
        if (!clk_s2 || clk_edge) begin
          next_rec_cnt = '0;
        end else if (rec_cnt == REC_LAST) begin
          next_state   = SSIP_READY;
          next_rec_cnt = '0;
        end else begin
          next_rec_cnt = rec_cnt + 1'b1;
        end
      end
      default: begin
        next_state = SSIP_READY;
      end
    endcase
    next_link_ready = (next_state == SSIP_READY);
  end

  // frame registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state      <= SSIP_READY;
      snap       <= '0;
      rec_cnt    <= '0;
      link_ready <= 1'b1;
    end else begin
      state      <= next_state;
      snap       <= next_snap;
      rec_cnt    <= next_rec_cnt;
      link_ready <= next_link_ready;
    end
  end

  // ==========================================================
  // shifter on the serial clock
  // held in reset while ready; the snapshot is frozen long before
  // the first rising edge reads it, so no word crosses in motion
  logic                lrst;
  logic [POS_BITS-1:0] sh;
  logic [POS_BITS-1:0] next_sh;
  logic                next_sdo;
  logic                loaded;
  logic [5:0]          lcnt;
  logic [5:0]          next_lcnt;

  assign lrst = rst | link_ready;

  // first edge loads the word, later edges shift zeros in behind
  always_comb begin
    next_sh   = sh;
    next_sdo  = sdo;
    next_lcnt = (lcnt == 6'h3f) ? lcnt : lcnt + 1'b1;
    if (!loaded) begin
      next_sdo = snap[POS_BITS-1];
      next_sh  = snap << 1;
    end else begin
      next_sdo = sh[POS_BITS-1];
      next_sh  = sh << 1;
    end
  end

  // line rests high while ready
  always_ff @(posedge ssi_clk or posedge lrst) begin
    if (lrst) begin
      sdo    <= 1'b1;
      sh     <= '0;
      loaded <= 1'b0;
      lcnt   <= 6'h00;
    end else begin
      sdo    <= next_sdo;
      sh     <= next_sh;
      loaded <= 1'b1;
      lcnt   <= next_lcnt;
    end
  end

  // ==========================================================
  // checks on ref_clk
  property p_cw_up;
    @(posedge ref_clk) disable iff (rst)
      (rot_cw && !rot_ccw && !dir_s2 && !zero_hit) |=> (position == $past(position) + 1'b1);
  endproperty
  a_cw_up: assert property (p_cw_up) else $error("cw step did not count up");

  property p_ccw_up;
    @(posedge ref_clk) disable iff (rst)
      (rot_ccw && !rot_cw && dir_s2 && !zero_hit) |=> (position == $past(position) + 1'b1);
  endproperty
  a_ccw_up: assert property (p_ccw_up) else $error("ccw step did not count up");

  property p_capture;
    @(posedge ref_clk) disable iff (rst)
      (link_ready && clk_fall) |=> (!link_ready && snap == $past(code));
  endproperty
  a_capture: assert property (p_capture) else $error("fall did not capture position");

  property p_recover;
    @(posedge ref_clk) disable iff (rst)
      $rose(link_ready) |-> ($past(rec_cnt) == REC_LAST && $past(clk_s2));
  endproperty
  a_recover: assert property (p_recover) else $error("ready before recovery time");

  property p_hold_busy;
    @(posedge ref_clk) disable iff (rst)
      (!link_ready && !clk_s2) |=> !link_ready;
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("ready while clock low");

  property p_zero;
    @(posedge ref_clk) disable iff (rst)
      (zero_rel && zero_cnt >= ZERO_MAX) |=> (position == '0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero release did not clear");

  property p_idle_high;
    @(posedge ref_clk) disable iff (rst)
      (link_ready && $past(link_ready)) |-> sdo;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("data low while idle");

  generate
    if (GRAY) begin : g_gray_chk
      property p_gray;
        @(posedge ref_clk) disable iff (rst)
          (position == $past(position) + 1'b1) |-> ($countones(code ^ $past(code)) == 1);
      endproperty
      a_gray: assert property (p_gray) else $error("gray step changed several bits");
    end
  endgenerate

  // ==========================================================
  // checks on the serial clock
  property p_msb;
    @(posedge ssi_clk) disable iff (lrst)
      (lcnt == 6'h01) |-> (sdo == snap[POS_BITS-1]);
  endproperty
  a_msb: assert property (p_msb) else $error("first bit is not msb");

  property p_lsb;
    @(posedge ssi_clk) disable iff (lrst)
      (lcnt == 6'(POS_BITS)) |-> (sdo == snap[0]);
  endproperty
  a_lsb: assert property (p_lsb) else $error("last word bit is not lsb");

  property p_trail_zero;
    @(posedge ssi_clk) disable iff (lrst)
      (lcnt > 6'(POS_BITS)) |-> !sdo;
  endproperty
  a_trail_zero: assert property (p_trail_zero) else $error("extra clock gave a one");

  // ==========================================================
  // main scenarios
  c_frame:  cover property (@(posedge ref_clk) disable iff (rst) $rose(link_ready));
  c_extra:  cover property (@(posedge ssi_clk) disable iff (lrst) lcnt == 6'(POS_BITS + 2));
  c_zero:   cover property (@(posedge ref_clk) disable iff (rst) zero_hit);
  c_ccw:    cover property (@(posedge ref_clk) disable iff (rst) dir_s2 && rot_ccw);

endmodule : ssip_transmitter

// ---- dv/ssip_master.sv ----
/*
  serial clock master model: sends bursts of clocks and samples the data bits.
  assumes the device changes its data just after each rising serial clock edge.
*/
`timescale 1ns/1ps

module ssip_master (
  output logic      ssi_clk,
  input  wire logic sdo,
  input  wire logic sdo_aux
);
  // ==========================================================
  // clock rests high between bursts
  initial ssi_clk = 1'b1;

  // one burst of n rising edges, bits of both data lines gathered msb first
  task automatic frame(input int n, output logic [31:0] bits, output logic [31:0] bits_aux);
    bits     = '0;
    bits_aux = '0;
    #3; // keeps link edges off the ref_clk edges
    ssi_clk = 1'b0;
    #60;
    for (int k = 0; k < n; k++) begin
      ssi_clk = 1'b1; // 30 ns period; a high phase longer than the 12 us recovery ends the frame
      #14;
      bits     = {bits[30:0], sdo};
      bits_aux = {bits_aux[30:0], sdo_aux};
      #1;
      if (k < n - 1) begin
        ssi_clk = 1'b0;
        #15;
      end
    end
  endtask : frame
endmodule : ssip_master

// ---- dv/ssi_position_transmitter_bench.sv ----
/*
  bench of the serial position transmitter: rotation, zeroing and frames
  against an integer model. assumes ssip_master drives the serial clock.
*/
`timescale 1ns/1ps

module ssi_position_transmitter_bench;
  localparam int PB   = 16;
  localparam int ZC   = 20;
  localparam int MASK = (1 << PB) - 1;

  logic          ref_clk     = 1'b0;
  logic          rst         = 1'b1;
  logic          rot_cw      = 1'b0;
  logic          rot_ccw     = 1'b0;
  logic          dir_ccw     = 1'b0;
  logic          zero_in     = 1'b0;
  logic          ssi_clk;
  logic          sdo;
  logic          sdo_g;
  logic          link_ready;
  logic [PB-1:0] position;
  logic [31:0]   seed        = 32'h0000_000b;
  logic [31:0]   bits;
  logic [31:0]   bits_g;
  int            n_errors    = 0;
  int            comparisons = 0;
  int            model       = 0;

  // ==========================================================
  // clock, design and master
  always #5 ref_clk = ~ref_clk;

  ssip_transmitter #(.POS_BITS(PB), .GRAY(1'b0), .ZERO_CYC(ZC)) dut (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .ssi_clk    (ssi_clk),
    .rot_cw     (rot_cw),
    .rot_ccw    (rot_ccw),
    .dir_ccw    (dir_ccw),
    .zero_in    (zero_in),
    .sdo        (sdo),
    .link_ready (link_ready),
    .position   (position)
  );

  // gray variant on the same pins and link clock
  ssip_transmitter #(.POS_BITS(PB), .GRAY(1'b1), .ZERO_CYC(ZC)) dut_gray (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .ssi_clk    (ssi_clk),
    .rot_cw     (rot_cw),
    .rot_ccw    (rot_ccw),
    .dir_ccw    (dir_ccw),
    .zero_in    (zero_in),
    .sdo        (sdo_g),
    .link_ready (),
    .position   ()
  );

  ssip_master m (
    .ssi_clk (ssi_clk),
    .sdo     (sdo),
    .sdo_aux (sdo_g)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // random rotation pulses, position checked every cycle
  task automatic spin(input int n);
    logic [31:0] r;
    for (int i = 0; i <= n; i++) begin
      r = xs();
      @(negedge ref_clk);
      chk("position", model & MASK, 32'(position));
      rot_cw = (i < n) & r[0];
      rot_ccw = (i < n) & r[1];
      if (rot_cw != rot_ccw) model += (rot_cw ^ dir_ccw) ? 1 : -1;
    end
  endtask : spin

  // zero pin held for hold cycles then released
  task automatic zero(input int hold);
    @(negedge ref_clk);
    zero_in = 1'b1;
    repeat (hold) @(negedge ref_clk);
    zero_in = 1'b0;
    repeat (6) @(negedge ref_clk);
    if (hold >= ZC) model = 0;
    chk("zeroed", model & MASK, 32'(position));
  endtask : zero

  // one frame of n clocks, then recovery and idle level
  task automatic read(input int n);
    int          cnt;
    logic [31:0] exp;
    logic [31:0] gexp;
    chk("idle sdo", 32'd1, 32'(sdo));
    chk("idle sdo gray", 32'd1, 32'(sdo_g));
    exp = (model & MASK) << (n - PB);
    gexp = ((model & MASK) ^ ((model & MASK) >> 1)) << (n - PB);
    m.frame(n, bits, bits_g);
    chk("frame", exp, bits);
    chk("gray frame", gexp, bits_g);
    chk("busy", 32'd0, 32'(link_ready));
    cnt = 0;
    while (link_ready !== 1'b1 && cnt < 2000) begin
      @(negedge ref_clk);
      cnt++;
    end
    chk("recovery", 32'd1, 32'(cnt >= 1195 && cnt < 1300));
    #1;
    chk("ready sdo", 32'd1, 32'(sdo));
    repeat (500) @(negedge ref_clk);
  endtask : read

  task automatic final_report();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    spin(200);
    read(PB);
    spin(50);
    read(PB + 3);
    @(negedge ref_clk);
    dir_ccw = 1'b1;
    zero(ZC + 4);
    spin(200);
    read(PB);
    zero(ZC / 2);
    zero(ZC + 4);
    read(PB);
    final_report();
  end

  // hang guard
  initial begin
    #300000;
    n_errors++;
    final_report();
  end
endmodule : ssi_position_transmitter_bench
